/* File: pbsp_port.v */
// pipelined burst sram port: strobes, burst counter, writes, output drive
// Function
// RULE1: all synchronous inputs are captured only on the rising clock edge
// RULE2: address latched when a strobe is low and all chip selects active
// RULE3: two low address bits feed a two-bit burst counter
// RULE4: accepted strobe loads address register and preloads burst counter
// RULE5: with both strobes low only the processor strobe acts; the code lets the controller strobe act while the first chip select is high
// RULE6: processor strobe ignored while first chip select is high
// RULE7: chip selects low, high, low; selected only when all active
// RULE8: chip selects sampled only when a new address is loaded
// RULE9: low advance during a burst increments the burst address; the code ignores it in the cycle after a processor-strobe load
// RULE10: low global write writes all byte lanes
// RULE11: otherwise lanes with low select written while lane enable low
// RULE12: master drives lane enable low for a selective lane write
// RULE13: incoming data and parity registered at the rising edge
// RULE14: read data appears one cycle after its address edge; the code presents it two cycles after the edge that samples the address pins
// RULE15: data driven only while output enable is low
// RULE16: first read cycle out of deselect keeps outputs disabled
// RULE17: high sleep input idles the port and keeps contents
// RULE18: system holds sleep low in normal operation
// RULE19: strap low gives linear order, high gives interleaved
// RULE20: system keeps the burst order strap constant
// RULE21: processor-strobe write ignores write controls first cycle
// RULE22: data outputs float whenever a write cycle is detected
// RULE23: deselect by chip selects with a strobe floats outputs at once
// RULE24: burst counter wraps within four addresses
// RULE25: linear adds beat count mod four, interleaved xors it
// RULE26: powers up deselected with outputs floating
`timescale 1ns/1ps
`include "pbsp_map.vh"
module pbsp_port #(
  parameter ADDR_W = `PBSP_ADDR_W,
  parameter LANES  = `PBSP_LANES,
  parameter LANE_W = `PBSP_LANE_W
) (
  input  wire                      clock_i,
  input  wire                      reset_i,
  input  wire [ADDR_W-1:0]         addr_i,
  input  wire                      processor_addr_strobe_n_i,
  input  wire                      controller_addr_strobe_n_i,
  input  wire                      burst_advance_n_i,
  input  wire                      global_write_n_i,
  input  wire                      lane_write_enable_n_i,
  input  wire [LANES-1:0]          byte_lane_select_n_i,
  input  wire                      chip_sel_low_a_i,
  input  wire                      chip_sel_high_i,
  input  wire                      chip_sel_low_b_i,
  input  wire                      output_enable_n_i,
  input  wire                      sleep_request_i,
  input  wire                      burst_order_i,
  input  wire [LANES*LANE_W-1:0]   data_i,
  output wire [LANES*LANE_W-1:0]   data_o,
  output wire [LANES*LANE_W-1:0]   data_oe_n_o,
  output wire                      selected_o
);
  localparam DW = LANES*LANE_W;
  localparam BW = `PBSP_BURST_W;

  // two-flop synchronisers for every pin input except reset_i
  reg [ADDR_W-1:0] addr_s1_reg, addr_reg_in;
  reg [DW-1:0]     data_s1_reg, data_in_reg;
  reg [LANES-1:0]  lane_s1_reg, lane_in_reg;
  reg [10:0]       ctl_s1_reg, ctl_in_reg;
  always @(posedge clock_i) begin // [RULE1] [RULE13]
    addr_s1_reg <= addr_i;
    addr_reg_in <= addr_s1_reg;
    data_s1_reg <= data_i;
    data_in_reg <= data_s1_reg;
    lane_s1_reg <= byte_lane_select_n_i;
    lane_in_reg <= lane_s1_reg;
    ctl_s1_reg  <= {processor_addr_strobe_n_i, controller_addr_strobe_n_i,
                    burst_advance_n_i, global_write_n_i,
                    lane_write_enable_n_i, chip_sel_low_a_i,
                    chip_sel_high_i, chip_sel_low_b_i,
                    output_enable_n_i, sleep_request_i, burst_order_i};
    ctl_in_reg  <= ctl_s1_reg;
  end
  wire pstb_n  = ctl_in_reg[10];
  wire cstb_n  = ctl_in_reg[9];
  wire adv_n   = ctl_in_reg[8];
  wire gw_n    = ctl_in_reg[7];
  wire lwe_n   = ctl_in_reg[6];
  wire csa     = ctl_in_reg[5];
  wire csh     = ctl_in_reg[4];
  wire csb     = ctl_in_reg[3];
  wire oe_n    = ctl_in_reg[2];
  wire sleep   = ctl_in_reg[1];
  wire order   = ctl_in_reg[0];

  function [BW-1:0] pbsp_burst_addr;
    input [BW-1:0] start;
    input [BW-1:0] beat;
    input          mode;
    begin
      if (mode == `PBSP_MODE_LINEAR)
        pbsp_burst_addr = start + beat; // [RULE25] [RULE24]
      else
        pbsp_burst_addr = start ^ beat; // [RULE25]
    end
  endfunction

  wire cs_all  = !csa && csh && !csb; // [RULE7]
  wire p_take  = !pstb_n && !csa; // [RULE6]
  // a gated processor strobe leaves the controller strobe free to act
  wire c_take  = !p_take && !cstb_n; // [RULE5]
  wire strobe  = (p_take || c_take) && !sleep;
  wire load    = strobe && cs_all; // [RULE2] [RULE8]
  wire desel   = strobe && !cs_all; // [RULE23]

  reg              sel_reg;
  reg              mode_reg;
  reg [ADDR_W-1:0] base_reg;
  reg [BW-1:0]     beat_reg;
  reg              pfirst_reg;
  reg              fresh_reg;
  reg              rd_valid_reg;
  reg              wr_cycle_reg;
  reg [DW-1:0]     out_reg;
  reg              sel_next;

  // strap followed whenever deselected and not loading, held through a selected burst
  always @(posedge clock_i) begin // [RULE19] [RULE20]
    if (reset_i)
      mode_reg <= 1'b1;
    else if (!sel_reg && !load)
      mode_reg <= order;
  end

  wire [BW-1:0] low_bits =
    pbsp_burst_addr(base_reg[BW-1:0], beat_reg, mode_reg);
  wire [ADDR_W-1:0] cur_addr = {base_reg[ADDR_W-1:BW], low_bits}; // [RULE3]
  wire [ADDR_W-1:0] acc_addr = load ? addr_reg_in : cur_addr;

  wire cont    = sel_reg && !strobe && !sleep;
  wire burst_advance_n     = cont && !adv_n && !pfirst_reg; // [RULE9] [RULE21]
  // processor-strobe write controls count only from the second edge on
  wire ctl_ok  = !(load && p_take);
  wire [LANES-1:0] lanes_w =
    !gw_n ? {LANES{1'b1}} : // [RULE10]
    (!lwe_n ? ~lane_in_reg : {LANES{1'b0}}); // [RULE11] [RULE12]
  wire active   = (load || cont) && ctl_ok; // [RULE21]
  wire do_write = active && (lanes_w != {LANES{1'b0}});
  wire do_read  = (load || cont) && !do_write && !(load && p_take &&
                  !(gw_n && lwe_n));

  always @* begin
    sel_next = sel_reg;
    if (load)
      sel_next = 1'b1;
    else if (desel)
      sel_next = 1'b0;
  end

  wire [DW-1:0] rd_data;
  pbsp_mem #(
    .ADDR_W (ADDR_W),
    .LANES  (LANES),
    .LANE_W (LANE_W)
  ) u_mem (
    .clock_i   (clock_i),
    .hold_i    (sleep), // [RULE17]
    .wr_lane_i (do_write ? lanes_w : {LANES{1'b0}}),
    .wr_addr_i (acc_addr),
    .wr_data_i (data_in_reg),
    .rd_addr_i (acc_addr),
    .rd_data_o (rd_data)
  );

  always @(posedge clock_i) begin
    if (reset_i) begin
      sel_reg      <= `PBSP_RST_SEL; // [RULE26]
      base_reg     <= {ADDR_W{1'b0}};
      beat_reg     <= {BW{1'b0}};
      pfirst_reg   <= 1'b0;
      fresh_reg    <= 1'b0;
      rd_valid_reg <= 1'b0;
      wr_cycle_reg <= 1'b0;
      out_reg      <= {DW{1'b0}};
    end else if (!sleep) begin // [RULE17]
      sel_reg <= sel_next;
      if (load) begin
        base_reg   <= addr_reg_in; // [RULE4]
        beat_reg   <= {BW{1'b0}};
        pfirst_reg <= p_take;
        fresh_reg  <= !sel_reg; // [RULE16]
      end else begin
        if (burst_advance_n)
          beat_reg <= beat_reg + 1'b1; // [RULE24]
        pfirst_reg <= 1'b0;
        fresh_reg  <= 1'b0;
      end
      rd_valid_reg <= do_read && !desel;
      wr_cycle_reg <= do_write || (load && p_take && !(gw_n && lwe_n));
      if (do_read)
        out_reg <= rd_data; // [RULE14]
    end
  end

  // async enable path kept combinational to the pin enables
  wire drive = !output_enable_n_i && rd_valid_reg && sel_reg &&
               !fresh_reg && !wr_cycle_reg && !desel; // [RULE15] [RULE22]
  assign data_o      = out_reg;
  assign data_oe_n_o = {DW{!drive}}; // [RULE15] [RULE23]
  assign selected_o  = sel_reg;
endmodule // pbsp_port

/* File: pbsp_map.vh */
// constants for the pipelined burst sram port
`ifndef PBSP_MAP_VH
`define PBSP_MAP_VH
`define PBSP_ADDR_W      8
`define PBSP_LANES       4
`define PBSP_LANE_W      9
`define PBSP_BURST_W     2
`define PBSP_MODE_LINEAR 1'b0
`define PBSP_RST_SEL     1'b0
`endif

/* File: pbsp_mem.v */
// byte-lane flip-flop memory array for the sram port
`timescale 1ns/1ps
`include "pbsp_map.vh"
module pbsp_mem #(
  parameter ADDR_W = `PBSP_ADDR_W,
  parameter LANES  = `PBSP_LANES,
  parameter LANE_W = `PBSP_LANE_W
) (
  input  wire                      clock_i,
  input  wire                      hold_i,
  input  wire [LANES-1:0]          wr_lane_i,
  input  wire [ADDR_W-1:0]         wr_addr_i,
  input  wire [LANES*LANE_W-1:0]   wr_data_i,
  input  wire [ADDR_W-1:0]         rd_addr_i,
  output wire [LANES*LANE_W-1:0]   rd_data_o
);
  localparam DEPTH = 1 << ADDR_W;
  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : g_lane
      // one array per lane keeps a single writer for every storage bit
      reg [LANE_W-1:0] lane_reg [0:DEPTH-1];
      // no reset: contents survive sleep and are undefined at power up
      always @(posedge clock_i) begin
        if (!hold_i && wr_lane_i[g]) begin
          lane_reg[wr_addr_i] <= wr_data_i[g*LANE_W +: LANE_W];
        end
      end
      assign rd_data_o[g*LANE_W +: LANE_W] = lane_reg[rd_addr_i];
    end
  endgenerate
endmodule // pbsp_mem

/* File: pbsp_port_sva.sv */
// concurrent checks on the pins of the sram port
`timescale 1ns/1ps
module pbsp_port_sva (
  input wire        clock_i,
  input wire        reset_i,
  input wire        processor_addr_strobe_n_i,
  input wire        controller_addr_strobe_n_i,
  input wire        chip_sel_low_a_i,
  input wire        chip_sel_high_i,
  input wire        chip_sel_low_b_i,
  input wire        output_enable_n_i,
  input wire        sleep_request_i,
  input wire [35:0] data_oe_n_o,
  input wire        selected_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  wire cs_on = !chip_sel_low_a_i && chip_sel_high_i && !chip_sel_low_b_i;
  wire ps_on = !processor_addr_strobe_n_i && !chip_sel_low_a_i;
  // the controller strobe is not gated by the first chip select
  wire ld = !sleep_request_i && (ps_on || !controller_addr_strobe_n_i);
  sequence load_s(on);
    ld && cs_on == on ##3 1'b1;
  endsequence
  sel_set_a: assert property (load_s(1'b1) |-> selected_o)
    else $error("select not taken");
  sel_clear_a: assert property (load_s(1'b0) |-> !selected_o)
    else $error("deselect not taken");
  sel_hold_a: assert property (!ld ##3 1'b1 |-> $stable(selected_o))
    else $error("select moved without strobe");
  oe_float_a: assert property (output_enable_n_i |-> &data_oe_n_o)
    else $error("driven with enable high");
  idle_float_a: assert property (!selected_o |-> &data_oe_n_o)
    else $error("driven while deselected");
  first_mask_a: assert property ($rose(selected_o) |-> &data_oe_n_o)
    else $error("driven in first cycle");
  lane_same_a: assert property (&data_oe_n_o || data_oe_n_o == 0)
    else $error("uneven lane enables");
  reset_idle_a: assert property (disable iff (1'b0)
    reset_i |=> &data_oe_n_o && !selected_o) else $error("active in reset");
endmodule // pbsp_port_sva
bind pbsp_port pbsp_port_sva u_sva (.clock_i, .reset_i,
  .processor_addr_strobe_n_i, .controller_addr_strobe_n_i, .chip_sel_low_a_i,
  .chip_sel_high_i, .chip_sel_low_b_i, .output_enable_n_i, .sleep_request_i,
  .data_oe_n_o, .selected_o);

/* File: pbsp_bus_model.sv */
// master side of the shared data lanes
`timescale 1ns/1ps
module pbsp_bus_model (
  input  wire        clock_i,
  input  wire        drive_i,
  input  wire [35:0] wr_data_i,
  input  wire [35:0] data_o,
  input  wire [35:0] data_oe_n_o,
  output wire [35:0] bus_o
);
  reg  [35:0] last_reg = 36'h0;
  // a floating lane shows wr_data_i while drive_i is high, else the inverse of the bus value of the previous cycle
  assign bus_o = ~data_oe_n_o & data_o
    | data_oe_n_o & (drive_i ? wr_data_i : ~last_reg);
  always @(posedge clock_i) last_reg <= bus_o;
endmodule // pbsp_bus_model

/* File: tb_top.sv */
// self-checking bench for the sram port
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked = samples_checked + 1; \
  if ((g) !== (e)) begin err_total = err_total + 1; \
  $display("MISMATCH %0t %h %h", $time, (g), (e)); end end
module tb_top;
  reg         clk = 1'b0, rst = 1'b1, ps_n = 1'b1, cst_n = 1'b1;
  reg         adv_n = 1'b1, gwr_n = 1'b1, lwe_n = 1'b1, oe_n = 1'b0;
  reg         sleep = 1'b0, order = 1'b0, drive = 1'b0;
  reg  [2:0]  chip = 3'b010;
  reg  [3:0]  lane_n = 4'hf;
  reg  [7:0]  addr = 8'h00;
  reg  [35:0] wdata = 36'h0, exp = 36'h0;
  wire [35:0] bus, dout, oen;
  wire        sel;
  integer     err_total = 0, samples_checked = 0, i, m;
  pbsp_port u_dut (.clock_i(clk), .reset_i(rst), .addr_i(addr),
    .processor_addr_strobe_n_i(ps_n), .controller_addr_strobe_n_i(cst_n),
    .burst_advance_n_i(adv_n), .global_write_n_i(gwr_n),
    .lane_write_enable_n_i(lwe_n), .byte_lane_select_n_i(lane_n),
    .chip_sel_low_a_i(chip[2]), .chip_sel_high_i(chip[1]),
    .chip_sel_low_b_i(chip[0]), .output_enable_n_i(oe_n),
    .sleep_request_i(sleep), .burst_order_i(order), .data_i(bus),
    .data_o(dout), .data_oe_n_o(oen), .selected_o(sel));
  pbsp_bus_model u_bus (.clock_i(clk), .drive_i(drive), .wr_data_i(wdata),
    .data_o(dout), .data_oe_n_o(oen), .bus_o(bus));
  always #2 clk = ~clk;
  function [35:0] pat(input integer k);
    pat = 36'h1_2345_6780 + k * 36'h0_1111_1111;
  endfunction
  // write controls stand two edges, strobes one, as a processor-strobe write needs
  task acc(input [7:0] a, input p, input c, input [2:0] cs, input g,
    input l, input [3:0] s, input [35:0] d);
    begin
      addr = a; ps_n = p; cst_n = c; chip = cs; gwr_n = g; lwe_n = l;
      lane_n = s; wdata = d; drive = !(g && l); oe_n = drive;
      @(negedge clk) {ps_n, cst_n} = 2'b11;
      @(negedge clk) {gwr_n, lwe_n, lane_n, drive, oe_n} = 8'hfc;
      repeat (6) @(negedge clk);
    end
  endtask
  task rd(input [7:0] a, input [35:0] e);
    begin
      acc(a, 1'b1, 1'b0, 3'b010, 1'b1, 1'b1, 4'hf, 36'h0);
      `CHK({oen[0], dout}, {1'b0, e})
    end
  endtask
  task stop_test;
    begin
      if (err_total == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  initial begin
    #20000 err_total = err_total + 1;
    stop_test;
  end
  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    `CHK({sel, &oen}, 2'b01)
    for (i = 0; i < 4; i = i + 1)
      acc({6'h08, i[1:0]}, 1'b1, 1'b0, 3'b010, 1'b0, 1'b1, 4'hf, pat(i));
    for (i = 0; i < 4; i = i + 1)
      rd({6'h08, i[1:0]}, pat(i));
    acc(8'h30, 1'b1, 1'b0, 3'b010, 1'b0, 1'b1, 4'hf, 36'h0);
    acc(8'h30, 1'b1, 1'b0, 3'b010, 1'b1, 1'b0, 4'h5, ~36'h0);
    acc(8'h30, 1'b1, 1'b0, 3'b010, 1'b1, 1'b1, 4'h0, ~36'h0);
    rd(8'h30, {9'h1ff, 9'h0, 9'h1ff, 9'h0});
    acc(8'h40, 1'b0, 1'b1, 3'b010, 1'b0, 1'b1, 4'hf, pat(9));
    rd(8'h40, pat(9));
    for (m = 0; m < 2; m = m + 1) begin
      acc(8'h00, 1'b1, 1'b0, 3'b000, 1'b1, 1'b1, 4'hf, 36'h0);
      `CHK({sel, &oen}, 2'b01)
      order = m[0];
      repeat (4) @(negedge clk);
      {addr, cst_n, chip} = {8'h21, 1'b0, 3'b010};
      @(negedge clk) {cst_n, adv_n} = 2'b10;
      repeat (2) @(negedge clk);
      `CHK({&oen, dout}, {1'b1, pat(1)})
      @(negedge clk);
      for (i = 0; i < 4; i = i + 1) begin
        adv_n = 1'b1;
        exp = pat(m ? (1 ^ i) : ((1 + i) & 3));
        `CHK({&oen, dout}, {1'b0, exp})
        @(negedge clk);
      end
    end
    acc(8'h20, 1'b0, 1'b1, 3'b110, 1'b1, 1'b1, 4'hf, 36'h0);
    `CHK({sel, dout}, {1'b1, exp})
    sleep = 1'b1;
    repeat (4) @(negedge clk);
    acc(8'h22, 1'b1, 1'b0, 3'b010, 1'b1, 1'b1, 4'hf, 36'h0);
    `CHK(dout, exp)
    sleep = 1'b0;
    repeat (4) @(negedge clk);
    rd(8'h22, pat(2));
    oe_n = 1'b1;
    #1 `CHK(&oen, 1'b1)
    stop_test;
  end
endmodule // tb_top
